/* rtl/lcd_host_pkg.sv */
// constants and carrier types for the display module host port
// assumes a single 25 MHz system clock; pin timings are rounded to whole cycles
package lcd_host_pkg;
  // ************************************************************
  // clock and pin timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_LOW_NS = 70;
  localparam int STROBE_HIGH_NS = 30;
  localparam int CYCLE_NS = 166;
  localparam int DATA_HOLD_NS = 10;
  localparam int INIT_LOW_NS = 500;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_RAW = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
  localparam int HIGH_RAW = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_RAW = CYCLE_CYC - STROBE_LOW_CYC - HOLD_CYC;
  localparam int GAP_CYC = (GAP_RAW > HIGH_RAW) ? GAP_RAW : HIGH_RAW;
  localparam int INIT_LOW_CYC = (INIT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  localparam int BUS_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] INIT_RESET = 5'h00;

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef struct packed {
    logic is_read;
    logic is_display;
    logic [BUS_W-1:0] data;
  } host_req_t;
  localparam int REQ_W = $bits(host_req_t);

  typedef struct packed {
    logic chip_select_n;
    logic module_init_n;
    logic cmd_data_select;
    logic wr_strobe_n;
    logic rd_strobe_n;
    logic enable;
    logic rd_dir;
  } pin_ctl_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100,
    ST_GAP = 3'b101
  } port_state_t;
endpackage

/* rtl/req_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module req_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;
  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // full is judged on the count alone; the pointers wrap and cannot tell full from empty
  assign in_ready = (st.count < (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = mem[st.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
    if (push)
    begin
      mem[st.wr_ptr] <= in_data;
    end
  end
endmodule

/* rtl/lcd_host_port.sv */
// host controller driving the display module parallel port from a request stream
// assumes pins are sampled on sys_clk; bus_style_select is a static strap
`timescale 1ns/1ps
module lcd_host_port
  import lcd_host_pkg::*;
#(
  parameter int DEPTH = lcd_host_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic bus_style_select,
  input wire logic req_valid,
  output logic req_ready,
  input wire lcd_host_pkg::host_req_t req,
  output logic rsp_valid,
  output logic [lcd_host_pkg::BUS_W-1:0] rsp_data,
  output logic chip_select_n,
  output logic module_init_n,
  output logic cmd_data_select,
  output logic wr_strobe_n,
  output logic rd_strobe_n,
  output logic enable,
  output logic rd_dir,
  input wire logic [lcd_host_pkg::BUS_W-1:0] bus_in,
  output logic [lcd_host_pkg::BUS_W-1:0] bus_out,
  output logic bus_oe,
  output logic busy
);
  import lcd_host_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    port_state_t fsm;
    logic [CNT_W-1:0] cnt;
    logic style;
    host_req_t cur;
    pin_ctl_t pins;
    logic [BUS_W-1:0] dout;
    logic oe;
    logic rv;
    logic [BUS_W-1:0] rd;
    logic bsy;
  } port_t;
  port_t s;
  port_t next_s;

  logic f_valid;
  logic f_ready;
  host_req_t f_req;
  logic [REQ_W-1:0] f_bits;

  req_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_bits)
  );
  assign f_req = host_req_t'(f_bits);
  // the fifo drains only when the pin sequencer is idle, so a slow display stalls the source
  assign f_ready = (s.fsm == ST_IDLE);

  // ************************************************************
  // pin sequencer
  // ************************************************************
  always_comb
  begin
    next_s = s;
    next_s.rv = 1'b0;
    case (s.fsm)
      ST_INIT:
      begin
        next_s.pins.module_init_n = 1'b0;
        if (s.cnt == CNT_W'(INIT_LOW_CYC - 1))
        begin
          next_s.pins.module_init_n = 1'b1;
          next_s.style = bus_style_select;
          next_s.cnt = '0;
          next_s.fsm = ST_IDLE;
        end
        else
        begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      ST_IDLE:
      begin
        if (f_valid)
        begin
          next_s.cur = f_req;
          next_s.pins.chip_select_n = 1'b0;
          next_s.pins.cmd_data_select = f_req.is_display;
          next_s.pins.rd_dir = f_req.is_read;
          // host drives the byte only for writes; reads leave the bus to the module
          next_s.oe = !f_req.is_read;
          next_s.dout = f_req.data;
          next_s.fsm = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (s.style)
        begin
          next_s.pins.enable = 1'b1;
        end
        else if (s.cur.is_read)
        begin
          next_s.pins.rd_strobe_n = 1'b0;
        end
        else
        begin
          next_s.pins.wr_strobe_n = 1'b0;
        end
        next_s.cnt = '0;
        next_s.fsm = ST_STROBE;
      end
      ST_STROBE:
      begin
        if (s.cnt == CNT_W'(STROBE_LOW_CYC - 1))
        begin
          if (s.cur.is_read)
          begin
            next_s.rd = bus_in;
            next_s.rv = 1'b1;
          end
          // data and select stay put through the closing edge
          next_s.pins.wr_strobe_n = 1'b1;
          next_s.pins.rd_strobe_n = 1'b1;
          next_s.pins.enable = 1'b0;
          next_s.cnt = '0;
          next_s.fsm = ST_HOLD;
        end
        else
        begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      ST_HOLD:
      begin
        if (s.cnt == CNT_W'(HOLD_CYC - 1))
        begin
          next_s.pins.chip_select_n = 1'b1;
          next_s.oe = 1'b0;
          next_s.cnt = '0;
          next_s.fsm = ST_GAP;
        end
        else
        begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      ST_GAP:
      begin
        if (s.cnt >= CNT_W'(GAP_CYC - 1))
        begin
          next_s.cnt = '0;
          next_s.fsm = ST_IDLE;
        end
        else
        begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      default:
      begin
        next_s.fsm = ST_IDLE;
      end
    endcase
    // registered from the next state so the flag lines up with the state register
    next_s.bsy = (next_s.fsm != ST_IDLE);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.fsm <= ST_INIT;
      s.cnt <= INIT_RESET;
      // module init line stays low with the rest of the fields; select and strobes idle high
      s.pins.chip_select_n <= 1'b1;
      s.pins.wr_strobe_n <= 1'b1;
      s.pins.rd_strobe_n <= 1'b1;
      s.bsy <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign chip_select_n = s.pins.chip_select_n;
  assign module_init_n = s.pins.module_init_n;
  assign cmd_data_select = s.pins.cmd_data_select;
  assign wr_strobe_n = s.pins.wr_strobe_n;
  assign rd_strobe_n = s.pins.rd_strobe_n;
  assign enable = s.pins.enable;
  assign rd_dir = s.pins.rd_dir;
  assign bus_out = s.dout;
  assign bus_oe = s.oe;
  assign rsp_valid = s.rv;
  assign rsp_data = s.rd;
  assign busy = s.bsy;

  // ************************************************************
  // checks
  // ************************************************************
  a_strobe_needs_select: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!wr_strobe_n || !rd_strobe_n || enable) |-> !chip_select_n)
    else $error("strobe active without chip select");
  a_init_low_time: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(module_init_n) |-> $past(module_init_n, 8) == 1'b0)
    else $error("init pulse too short");
  a_select_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    !chip_select_n && !$rose(!chip_select_n) |-> $stable(cmd_data_select))
    else $error("selector changed inside access");
  a_write_data_held: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(wr_strobe_n) |-> bus_oe && $stable(bus_out) && !chip_select_n)
    else $error("write data not held over strobe edge");
  a_read_bus_free: assert property (@(posedge sys_clk) disable iff (!resetn)
    !rd_strobe_n |-> !bus_oe)
    else $error("host drives bus during read");
  a_style_exclusive: assert property (@(posedge sys_clk) disable iff (!resetn)
    enable |-> wr_strobe_n && rd_strobe_n)
    else $error("both strobe styles active");
  a_enable_width: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(enable) |-> enable [*2] ##1 !enable)
    else $error("enable pulse width wrong");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(!rd_strobe_n) |-> ##2 rsp_valid)
    else $error("read answer missing");
endmodule

/* tb/lcd_module_model.sv */
// behavioural model of the display module on the far side of the host port
// assumes the bench resolves nothing else on the data bus; bus_line is the wire
`timescale 1ns/1ps
module lcd_module_model (
  input wire logic bus_style_select,
  input wire logic chip_select_n,
  input wire logic module_init_n,
  input wire logic cmd_data_select,
  input wire logic wr_strobe_n,
  input wire logic rd_strobe_n,
  input wire logic enable,
  input wire logic rd_dir,
  input wire logic [lcd_host_pkg::BUS_W-1:0] bus_out,
  input wire logic bus_oe,
  input wire logic [lcd_host_pkg::BUS_W-1:0] rd_value,
  output logic [lcd_host_pkg::BUS_W-1:0] bus_line
);
  import lcd_host_pkg::*;
  // ****
  // capture log
  // ****
  logic [BUS_W-1:0] log_data [0:15];
  logic log_sel [0:15];
  int count = 0;
  logic [BUS_W-1:0] last = 8'h00;
  logic dev_drv;

  task automatic store();
    // qualifiers are read just after the edge, so a reset that lifts the strobe is not a write
    #1;
    if (module_init_n === 1'b1 && chip_select_n === 1'b0 && count < 16)
    begin
      log_data[count] = bus_line;
      log_sel[count] = cmd_data_select;
      count++;
    end
  endtask

  always @(posedge wr_strobe_n) if (bus_style_select === 1'b0) store();
  always @(negedge enable) if (bus_style_select === 1'b1 && rd_dir === 1'b0) store();
  always @(module_init_n) if (module_init_n === 1'b0) count = 0;

  // ****
  // bus drive
  // ****
  assign dev_drv = (chip_select_n === 1'b0) && (bus_style_select ? (enable === 1'b1 && rd_dir === 1'b1)
                   : rd_strobe_n === 1'b0);
  always @*
  begin
    if (bus_oe === 1'b1) last = bus_out;
    else if (dev_drv) last = rd_value;
  end
  // no pull-up: a released bus shows the inverse so stale data cannot pass
  assign bus_line = (bus_oe === 1'b1 || dev_drv) ? last : ~last;
endmodule

/* tb/tb_top.sv */
// self-checking bench for the display module host port
// assumes the model in lcd_module_model.sv stands on the pin side
`timescale 1ns/1ps
module tb_top;
  import lcd_host_pkg::*;
  logic sys_clk, resetn, bus_style_select, req_valid, req_ready, rsp_valid;
  host_req_t req;
  logic [BUS_W-1:0] rsp_data, bus_in, bus_out, rd_value;
  logic chip_select_n, module_init_n, cmd_data_select, wr_strobe_n, rd_strobe_n, enable, rd_dir, bus_oe, busy;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  lcd_host_port lcd_host_port_inst (.sys_clk(sys_clk), .resetn(resetn), .bus_style_select(bus_style_select),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .chip_select_n(chip_select_n), .module_init_n(module_init_n), .cmd_data_select(cmd_data_select),
    .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n), .enable(enable), .rd_dir(rd_dir),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .busy(busy));
  lcd_module_model lcd_module_model_inst (.bus_style_select(bus_style_select), .chip_select_n(chip_select_n),
    .module_init_n(module_init_n), .cmd_data_select(cmd_data_select), .wr_strobe_n(wr_strobe_n),
    .rd_strobe_n(rd_strobe_n), .enable(enable), .rd_dir(rd_dir), .bus_out(bus_out), .bus_oe(bus_oe),
    .rd_value(rd_value), .bus_line(bus_in));

  // ****
  // clock, watchdog, checks
  // ****
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run is under two hundred cycles; the ceiling only cuts a hang
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ****
  // drivers
  // ****
  task automatic push(input logic rd, input logic dsp, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{is_read: rd, is_display: dsp, data: d};
    // ready is looked at mid-cycle where it has settled; the request is taken at the next rising edge
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic sty);
    resetn <= 1'b0;
    bus_style_select <= sty;
    repeat (5) @(posedge sys_clk);
    check({7'h00, module_init_n}, 8'h00);
    check({7'h00, chip_select_n}, 8'h01);
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask

  // ****
  // scenarios
  // ****
  // fifo fills during the init hold, so it must refuse before any drain
  task automatic fill_and_drain(input logic [7:0] base);
    int i;
    for (i = 0; i < 8; i++) push(1'b0, i[0], base + 8'(i));
    req_valid <= 1'b0;
    @(posedge sys_clk);
    check({7'h00, req_ready}, 8'h00);
    check({7'h00, busy}, 8'h01);
    check({7'h00, module_init_n}, 8'h00);
    i = 0;
    while (lcd_module_model_inst.count < 8 && i < 300)
    begin
      @(posedge sys_clk);
      i++;
    end
    check(8'(lcd_module_model_inst.count), 8'h08);
    check({7'h00, module_init_n}, 8'h01);
    for (i = 0; i < 8; i++)
    begin
      check(lcd_module_model_inst.log_data[i], base + 8'(i));
      check({7'h00, lcd_module_model_inst.log_sel[i]}, {7'h00, i[0]});
    end
  endtask

  task automatic read_back(input logic [7:0] v);
    int n;
    n = 0;
    rd_value <= v;
    push(1'b1, 1'b0, 8'h00);
    req_valid <= 1'b0;
    // the answer pulse stands one full cycle, so a mid-cycle look cannot miss it
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    check({7'h00, rsp_valid}, 8'h01);
    check(rsp_data, v);
    check(8'(lcd_module_model_inst.count), 8'h08);
    @(posedge sys_clk);
  endtask

  initial
  begin
    resetn = 1'b0;
    bus_style_select = 1'b0;
    req_valid = 1'b0;
    req = '0;
    rd_value = 8'h00;
    @(posedge sys_clk);
    do_reset(1'b0);
    fill_and_drain(8'hA0);
    read_back(8'hC3);
    // reset lands in the middle of a write
    push(1'b0, 1'b1, 8'h55);
    req_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    do_reset(1'b1);
    check(8'(lcd_module_model_inst.count), 8'h00);
    fill_and_drain(8'h10);
    read_back(8'h3C);
    repeat (8) @(posedge sys_clk);
    check({7'h00, busy}, 8'h00);
    check({7'h00, chip_select_n}, 8'h01);
    complete_run();
  end
endmodule
